// ==== rtl/supply_guard_config.sv ====
// Supply guard registers, undervoltage lockout and supply saver clamp choice
`timescale 1ns/100ps
module supply_guard_config
  import supply_guard_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic [7:0] supply_level,
  input  wire logic [7:0] supply_decivolt,
  input  wire logic       effect_start,
  input  wire logic [7:0] overdrive_limit_one,
  input  wire logic [7:0] overdrive_limit_two,
  output logic            output_stage_off,
  output logic            standby_req,
  output logic [1:0]      clamp_sel,
  output logic            clamp_active,
  output logic [7:0]      overdrive_limit
);
  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // The control fields are sliced straight out of one 8-bit register, so a
  // moved field must still fit, keep its width and stay clear of the other
  if (LVL_EN_MSB - LVL_EN_LSB != 1) begin : gen_lvl_width_chk
    $error("level enable field must be two bits wide");
  end
  if (UV_SEL_MSB - UV_SEL_LSB != 2) begin : gen_uv_width_chk
    $error("undervoltage select field must be three bits wide");
  end
  if (LVL_EN_MSB > 7 || UV_SEL_LSB < 0) begin : gen_field_range_chk
    $error("control field lies outside the register");
  end
  if (LVL_EN_LSB <= UV_SEL_MSB) begin : gen_field_overlap_chk
    $error("control fields overlap");
  end
  // The top select code must not carry past the 8-bit decivolt scale
  if (int'(UV_BASE_DECIVOLT) + 7 > 255) begin : gen_uv_scale_chk
    $error("undervoltage threshold overflows eight bits");
  end
  // Clamp codes leave on a two-bit port
  if ($bits(clamp_sel_e) != 2) begin : gen_clamp_width_chk
    $error("clamp selection must be two bits wide");
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] thr_one_reg;
  logic [7:0] thr_two_reg;
  wire        sel_control = (reg_addr == ADDR_GUARD_CONTROL);
  wire        sel_thr_one = (reg_addr == ADDR_SAVER_THR_ONE);
  wire        sel_thr_two = (reg_addr == ADDR_SAVER_THR_TWO);
  wire        wr_control  = reg_wr && sel_control;
  wire        wr_thr_one  = reg_wr && sel_thr_one;
  wire        wr_thr_two  = reg_wr && sel_thr_two;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      control_reg <= RST_GUARD_CONTROL;
      thr_one_reg <= RST_SAVER_THR_ONE;
      thr_two_reg <= RST_SAVER_THR_TWO;
    end else begin
      if (wr_control) control_reg <= reg_wdata;
      if (wr_thr_one) thr_one_reg <= reg_wdata;
      if (wr_thr_two) thr_two_reg <= reg_wdata;
    end
  end

  // Unmapped addresses read zero; reserved bits are plain storage
  assign reg_rdata = sel_control ? control_reg :
                     sel_thr_one ? thr_one_reg :
                     sel_thr_two ? thr_two_reg : 8'h00;

  // Writes land on the next edge; nothing else may move a register
  thr_one_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_thr_one
    |=> thr_one_reg == $past(reg_wdata))
    else $error("threshold one write lost");
  thr_two_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_thr_two
    |=> thr_two_reg == $past(reg_wdata))
    else $error("threshold two write lost");
  ctl_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wr_control
    |=> $stable(control_reg))
    else $error("control changed without a write");
  thr_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(reg_wr && (reg_addr == ADDR_SAVER_THR_ONE || reg_addr == ADDR_SAVER_THR_TWO))
    |=> $stable(thr_one_reg) && $stable(thr_two_reg))
    else $error("threshold changed without a write");
  // First edge after release: every register still holds its reset value
  rst_vals_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(resetn)
    |-> control_reg == RST_GUARD_CONTROL && thr_one_reg == RST_SAVER_THR_ONE &&
        thr_two_reg == RST_SAVER_THR_TWO && clamp_sel == 2'(CLAMP_NONE))
    else $error("register not at reset value");
  rd_ctl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_addr == ADDR_GUARD_CONTROL |-> reg_rdata == control_reg)
    else $error("control read back wrong");
  rd_thr_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_addr == ADDR_SAVER_THR_ONE |-> reg_rdata == thr_one_reg)
    else $error("threshold one read back wrong");
  rd_thr_two_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_addr == ADDR_SAVER_THR_TWO |-> reg_rdata == thr_two_reg)
    else $error("threshold two read back wrong");

  // --------------------------------------------------------------------------
  // Undervoltage lockout
  // --------------------------------------------------------------------------
  wire [1:0] level_enable = control_reg[LVL_EN_MSB:LVL_EN_LSB];
  wire [2:0] uv_select    = control_reg[UV_SEL_MSB:UV_SEL_LSB];
  wire [7:0] uv_threshold = UV_BASE_DECIVOLT + {5'h00, uv_select};
  wire       uv_trip      = supply_decivolt < uv_threshold;
  // Combinational so the stage drops without waiting for a clock edge
  assign output_stage_off = uv_trip;
  assign standby_req      = uv_trip;

  // Sampled on the clock only; the trip path itself waits for no edge
  uv_pair_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    output_stage_off == standby_req)
    else $error("standby and stage off disagree");
  uv_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    supply_decivolt >= 8'(UV_BASE_DECIVOLT + uv_select)
    |-> !output_stage_off && !standby_req)
    else $error("undervoltage tripped above threshold");
  uv_min_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    uv_select == 3'h0 && supply_decivolt == 8'h18 |-> output_stage_off)
    else $error("bottom threshold too low");
  uv_base_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    uv_select == 3'h0 && supply_decivolt == 8'h19 |-> !output_stage_off)
    else $error("bottom threshold too high");
  uv_top_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    uv_select == 3'h7 && supply_decivolt == 8'h1F |-> output_stage_off)
    else $error("top threshold too low");

  // --------------------------------------------------------------------------
  // Supply saver decision
  // --------------------------------------------------------------------------
  // Value 3 is undefined and treated as disabled
  wire en_one = (level_enable == LVL_EN_ONE) || (level_enable == LVL_EN_BOTH);
  wire en_two = (level_enable == LVL_EN_BOTH);
  wire below_one = en_one && (supply_level < thr_one_reg);
  wire below_two = en_two && (supply_level < thr_two_reg);
  wire [1:0] clamp_next = below_two ? 2'(CLAMP_TWO) :
                          below_one ? 2'(CLAMP_ONE) : 2'(CLAMP_NONE);
  logic [1:0] clamp_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) clamp_reg <= 2'(CLAMP_NONE);
    else if (effect_start) clamp_reg <= clamp_next;
  end

  assign clamp_sel    = clamp_reg;
  assign clamp_active = clamp_reg != 2'(CLAMP_NONE);
  // Limit values are live inputs; software must not change them mid effect
  assign overdrive_limit = (clamp_reg == 2'(CLAMP_TWO)) ? overdrive_limit_two :
                           (clamp_reg == 2'(CLAMP_ONE)) ? overdrive_limit_one : 8'h00;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  clamp_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !effect_start |=> $stable(clamp_sel)) else $error("clamp changed mid effect");
  clamp_two_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && en_two && supply_level < thr_two_reg |=> clamp_sel == 2'(CLAMP_TWO))
    else $error("second limit not chosen");
  clamp_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && en_one && supply_level < thr_one_reg && !below_two
    |=> clamp_sel == 2'(CLAMP_ONE)) else $error("first limit not chosen");
  clamp_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && level_enable == LVL_EN_OFF |=> clamp_sel == 2'(CLAMP_NONE))
    else $error("saver active while disabled");
  uv_trip_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    supply_decivolt < 8'(UV_BASE_DECIVOLT + uv_select) |-> output_stage_off && standby_req)
    else $error("undervoltage not tripped");
  uv_max_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    uv_select == 3'h7 && supply_decivolt == 8'h20 |-> !output_stage_off)
    else $error("top threshold wrong");
  lim_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clamp_sel == 2'(CLAMP_TWO) |-> overdrive_limit == overdrive_limit_two)
    else $error("limit two not applied");
  wr_ctl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_control |=> control_reg == $past(reg_wdata)) else $error("control write lost");

  // Level decode, threshold order and the limit mux seen from the outputs
  clamp_lvl3_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && level_enable == 2'h3
    |=> clamp_sel == 2'(CLAMP_NONE))
    else $error("saver active on undefined level code");
  clamp_lvl1_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && level_enable == LVL_EN_ONE
    |=> clamp_sel != 2'(CLAMP_TWO))
    else $error("second level used while only first enabled");
  clamp_first_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && level_enable == LVL_EN_ONE && supply_level < thr_one_reg
    |=> clamp_sel == 2'(CLAMP_ONE))
    else $error("first level alone not applied");
  clamp_between_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && level_enable == LVL_EN_BOTH && supply_level < thr_one_reg &&
    supply_level >= thr_two_reg |=> clamp_sel == 2'(CLAMP_ONE))
    else $error("first limit not chosen between thresholds");
  clamp_above_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    effect_start && supply_level >= thr_one_reg && supply_level >= thr_two_reg
    |=> clamp_sel == 2'(CLAMP_NONE))
    else $error("clamp chosen above both thresholds");
  clamp_code_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clamp_sel != 2'h3)
    else $error("illegal clamp code");
  clamp_act_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clamp_active == (clamp_sel != 2'(CLAMP_NONE)))
    else $error("clamp active flag wrong");
  lim_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clamp_sel == 2'(CLAMP_ONE) |-> overdrive_limit == overdrive_limit_one)
    else $error("limit one not applied");
  lim_none_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clamp_sel == 2'(CLAMP_NONE) |-> overdrive_limit == 8'h00)
    else $error("limit applied with no clamp");
  clamp_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !effect_start && $changed(supply_level) |=> $stable(clamp_sel))
    else $error("clamp followed the supply mid effect");
endmodule // supply_guard_config

// ==== rtl/supply_guard_pkg.sv ====
// Constants for the supply guard configuration and clamp decision block
// ----------------------------------------------------------------------------
// Operation
// - Level enable field: 0 off, 1 first level only, 2 both levels.
// - Undervoltage select 0..7 picks 2.5 V up to 3.2 V in 0.1 V steps.
// - Supply under selected threshold: output stage off at once, go standby.
// - First level on, sample below threshold one and not below an enabled threshold two: use limit one; reset 146.
// - Second level on and sample below threshold two: use limit two; reset 141.
// - Supply sampled once at effect start; clamp choice held for the effect.
// ----------------------------------------------------------------------------
package supply_guard_pkg;
  localparam logic [7:0] ADDR_GUARD_CONTROL = 8'h09;
  localparam logic [7:0] ADDR_SAVER_THR_ONE = 8'h0A;
  localparam logic [7:0] ADDR_SAVER_THR_TWO = 8'h0B;
  localparam logic [7:0] RST_GUARD_CONTROL  = 8'h00;
  localparam logic [7:0] RST_SAVER_THR_ONE  = 8'h92;
  localparam logic [7:0] RST_SAVER_THR_TWO  = 8'h8D;
  localparam int         LVL_EN_MSB         = 7;
  localparam int         LVL_EN_LSB         = 6;
  localparam int         UV_SEL_MSB         = 2;
  localparam int         UV_SEL_LSB         = 0;
  localparam logic [1:0] LVL_EN_OFF         = 2'h0;
  localparam logic [1:0] LVL_EN_ONE         = 2'h1;
  localparam logic [1:0] LVL_EN_BOTH        = 2'h2;
  // Undervoltage threshold in 0.1 V units: code 0 = 25 (2.5 V), 7 = 32 (3.2 V)
  localparam logic [7:0] UV_BASE_DECIVOLT   = 8'h19;
  typedef enum logic [1:0] {CLAMP_NONE, CLAMP_ONE, CLAMP_TWO} clamp_sel_e;
endpackage

// ==== testbench/testbench.sv ====
// Self-checking bench for the supply guard block
`timescale 1ns/100ps
module testbench;
  import supply_guard_pkg::*;
  logic       clk_sys = 0, resetn = 0, reg_wr = 0, effect_start = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, supply_level = 0, supply_decivolt = 0;
  logic [7:0] overdrive_limit_one = 0, overdrive_limit_two = 0, reg_rdata, overdrive_limit;
  logic       output_stage_off, standby_req, clamp_active;
  logic [1:0] clamp_sel;
  int         error_cnt = 0, compares = 0, seed = 39908, ctl = 0, t1 = 146, t2 = 141, sel;
  int         exp_q[$];
  logic [7:0] wa, wd;
  supply_guard_config dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_level(supply_level), .supply_decivolt(supply_decivolt),
    .effect_start(effect_start), .overdrive_limit_one(overdrive_limit_one),
    .overdrive_limit_two(overdrive_limit_two), .output_stage_off(output_stage_off),
    .standby_req(standby_req), .clamp_sel(clamp_sel), .clamp_active(clamp_active),
    .overdrive_limit(overdrive_limit));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return 8'(seed);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys); #1 reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(posedge clk_sys); #1 reg_wr = 0;
    if (a == 8'h09) ctl = d; else if (a == 8'h0A) t1 = d; else if (a == 8'h0B) t2 = d;
    check(reg_rdata, a == 8'h09 ? ctl : a == 8'h0A ? t1 : a == 8'h0B ? t2 : 0);
  endtask
  task automatic rd_reset();
    for (int a = 9; a < 12; a++) begin
      @(posedge clk_sys); #1 reg_addr = 8'(a);
      #1 check(reg_rdata, a == 9 ? 8'h00 : a == 10 ? 8'h92 : 8'h8D);
    end
  endtask
  // Supply is scrambled after the sampling edge: the clamp choice must not follow it
  task automatic fx(input logic [7:0] lv);
    int en;
    en = ctl >> 6;
    @(posedge clk_sys); #1 supply_level = lv; effect_start = 1;
    overdrive_limit_one = rnd();
    overdrive_limit_two = 8'(rnd() % (overdrive_limit_one + 1));
    exp_q.push_back((en == 2 && lv < t2) ? 2 : ((en == 1 || en == 2) && lv < t1) ? 1 : 0);
    @(posedge clk_sys); #1 effect_start = 0; supply_level = rnd();
    sel = exp_q.pop_front();
    repeat (2) begin
      check(clamp_sel, sel);
      check(clamp_active, sel != 0);
      check(overdrive_limit, sel == 2 ? overdrive_limit_two : sel == 1 ? overdrive_limit_one : 0);
      @(posedge clk_sys); #1 supply_level = rnd();
    end
    supply_decivolt = 8'd20 + rnd() % 8'd21; #1;
    check(output_stage_off, supply_decivolt < 25 + (ctl & 7));
    check(standby_req, supply_decivolt < 25 + (ctl & 7));
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1;
    rd_reset();
    $display("reset values test done");
    wr(8'h0C, rnd());
    for (int e = 0; e < 4; e++) begin
      wr(8'h09, 8'(e << 6) | (rnd() & 8'h3F)); fx(rnd()); fx(8'(t1 - 1)); fx(8'(t2));
    end
    $display("enable codes test done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h09, 8'(c));
      for (int v = 23; v < 35; v++) begin
        @(posedge clk_sys); #1 supply_decivolt = 8'(v);
        #1 check(output_stage_off, v < 25 + c);
        check(standby_req, v < 25 + c);
      end
    end
    $display("undervoltage steps test done");
    // Threshold writes keep threshold one above threshold two
    repeat (60) begin
      wa = 8'h09 + rnd() % 3;
      wd = (wa == 8'h0A) ? 8'(t2 + 1 + rnd() % (255 - t2)) :
           (wa == 8'h0B) ? 8'(rnd() % t1) : rnd();
      wr(wa, wd);
      fx(rnd()); fx(8'(t1)); fx(8'(t2 - 1));
    end
    $display("random test done");
    wr(8'h0A, 8'hC0); wr(8'h0B, 8'h40); wr(8'h09, 8'h80); fx(8'h10);
    @(posedge clk_sys); #1 resetn = 0;
    ctl = 0;
    t1 = 146;
    t2 = 141;
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1;
    check(clamp_sel, 8'h00);
    rd_reset();
    wr(8'h09, 8'h40); fx(8'(t1 - 1));
    $display("mid-run reset test done");
    give_verdict();
  end
  initial begin
    // A clean run takes under 2000 cycles; this allows several times that
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule // testbench
